// ---- lpm_defines.svh ----
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// Register word addresses (byte offsets)
`define LPM_ADDR_SUPPLY_CTRL   8'h00
`define LPM_ADDR_MAIN_OSC      8'h04
`define LPM_ADDR_FAST_STARTUP  8'h08
`define LPM_ADDR_SYS_CTRL      8'h0C
`define LPM_ADDR_PM_STATUS     8'h10
`define LPM_ADDR_IRQ_STATUS    8'h14
`define LPM_ADDR_IRQ_MASK      8'h18
`define LPM_ADDR_WAKE_ENABLE   8'h1C
`define LPM_ADDR_WAKE_CONFIG   8'h20

// Supply control register fields
`define LPM_SC_REG_OFF_BIT     2
`define LPM_SC_XTAL_SEL_BIT    3
`define LPM_SC_KEY_LSB         24
`define LPM_SC_KEY_VALUE       8'hA5

// Main oscillator register fields
`define LPM_MO_WAIT_REQ_BIT    2
`define LPM_MO_KEY_LSB         16
`define LPM_MO_KEY_VALUE       8'h37

// Fast startup register fields
`define LPM_FS_FAST_LSB        0
`define LPM_FS_RTT_BIT         16
`define LPM_FS_RTC_BIT         17
`define LPM_FS_USB_BIT         18
`define LPM_FS_FLASH_LP_LSB    21

// System control register fields
`define LPM_SYS_DEEP_SLEEP_BIT 2

// Wake enable register fields
`define LPM_WE_SM_BIT          16
`define LPM_WE_RTT_BIT         17
`define LPM_WE_RTC_BIT         18

// Event bits in interrupt status and mask
`define LPM_EV_BACKUP_ENTER    0
`define LPM_EV_BACKUP_EXIT     1
`define LPM_EV_WAIT_ENTER      2
`define LPM_EV_WAIT_EXIT       3
`define LPM_EV_KEY_ERROR       4

// Timing
`define LPM_CLK_MHZ            10
`define LPM_WAIT_WAKE_US       10
`define LPM_WAIT_WAKE_CYCLES   ((`LPM_WAIT_WAKE_US * `LPM_CLK_MHZ) - 1)
`define LPM_RESTART_CYCLES     4
`define LPM_DEBOUNCE_DEFAULT   3

`endif

// ---- lpm_pkg.sv ----
package lpm_pkg;
  typedef enum logic [3:0] {
    LPM_ACTIVE  = 4'b0001,
    LPM_BACKUP  = 4'b0010,
    LPM_WAIT    = 4'b0100,
    LPM_RESTART = 4'b1000
  } lpm_state_e;
  typedef logic [15:0] lpm_pins_t;
endpackage : lpm_pkg

// ---- lpm_debounce.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpm_debounce #(
  parameter int WIDTH = 16,
  parameter int CW    = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [CW-1:0]    limit,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] stable,
  output logic      [WIDTH-1:0] changed
);
  logic [WIDTH-1:0]         stable_reg, stable_next;
  logic [WIDTH-1:0]         changed_reg, changed_next;
  logic [WIDTH-1:0][CW-1:0] cnt_reg, cnt_next;

  // A level must hold for limit+1 cycles before it counts as a transition
  always_comb begin
    stable_next  = stable_reg;
    changed_next = '0;
    cnt_next     = cnt_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_in[i] == stable_reg[i]) begin
        cnt_next[i] = '0;
      end else if (cnt_reg[i] >= limit) begin
        stable_next[i]  = pin_in[i];
        changed_next[i] = 1'b1;
        cnt_next[i]     = '0;
      end else begin
        cnt_next[i] = cnt_reg[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stable_reg  <= '0;
      changed_reg <= '0;
      cnt_reg     <= '0;
    end else if (ce) begin
      stable_reg  <= stable_next;
      changed_reg <= changed_next;
      cnt_reg     <= cnt_next;
    end
  end

  assign stable  = stable_reg;
  assign changed = changed_reg;
endmodule : lpm_debounce
`default_nettype wire

// ---- lpm_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lpm_defines.svh"
module lpm_ctrl #(
  parameter int DEB_W = 4
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire lpm_pkg::lpm_pins_t wake_pins,
  input  wire logic              supply_monitor_alarm,
  input  wire logic              real_time_timer_alarm,
  input  wire logic              calendar_alarm,
  input  wire logic              usb_wake,
  input  wire logic              wait_for_event_instruction,
  output logic                   regulator_on,
  output logic                   core_supply_on,
  output logic                   slow_osc_on,
  output logic                   slow_osc_xtal_sel,
  output logic                   core_clk_en,
  output logic                   periph_clk_en,
  output logic                   mem_clk_en,
  output logic                   supply_domain_on,
  output logic                   irq
);
  import lpm_pkg::*;

  lpm_state_e  state_reg, state_next;
  logic        xtal_reg, xtal_next;
  logic        deep_sleep_reg, deep_sleep_next;
  logic [15:0] fast_pins_reg, fast_pins_next;
  logic        fs_rtt_reg, fs_rtt_next, fs_rtc_reg, fs_rtc_next, fs_usb_reg, fs_usb_next;
  logic [1:0]  flash_lp_reg, flash_lp_next;
  logic [15:0] wake_pin_en_reg, wake_pin_en_next;
  logic        we_sm_reg, we_sm_next, we_rtt_reg, we_rtt_next, we_rtc_reg, we_rtc_next;
  logic [DEB_W-1:0] deb_lim_reg, deb_lim_next;
  logic        mck_rdy_reg, mck_rdy_next;
  logic [7:0]  wake_cnt_reg, wake_cnt_next;
  logic [4:0]  ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic        regulator_on_reg, regulator_on_next;
  logic        core_supply_on_reg, core_supply_on_next;
  logic        slow_osc_on_reg, slow_osc_on_next;
  logic        supply_domain_on_reg, supply_domain_on_next;
  logic        core_clk_en_reg, core_clk_en_next;
  logic        periph_clk_en_reg, periph_clk_en_next;
  logic        mem_clk_en_reg, mem_clk_en_next;
  logic [15:0] pins_changed;
  logic [4:0]  ev;
  logic        backup_wake, wait_wake, key_ok, osc_key_ok;

  lpm_debounce #(.WIDTH(16), .CW(DEB_W)) u_deb (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .limit   (deb_lim_reg),
    .pin_in  (wake_pins),
    .stable  (),
    .changed (pins_changed)
  );

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr && (addr == a);
  endfunction : wr_hit

  always_comb begin
    key_ok     = (wdata[`LPM_SC_KEY_LSB +: 8] == `LPM_SC_KEY_VALUE);
    osc_key_ok = (wdata[`LPM_MO_KEY_LSB +: 8] == `LPM_MO_KEY_VALUE);
    backup_wake = (|(pins_changed & wake_pin_en_reg))
                | (we_sm_reg & supply_monitor_alarm)
                | (we_rtt_reg & real_time_timer_alarm)
                | (we_rtc_reg & calendar_alarm);
    wait_wake = (|(pins_changed & fast_pins_reg))
              | (fs_rtt_reg & real_time_timer_alarm)
              | (fs_rtc_reg & calendar_alarm)
              | (fs_usb_reg & usb_wake);
  end

  // Power state machine
  always_comb begin
    state_next    = state_reg;
    wake_cnt_next = wake_cnt_reg;
    mck_rdy_next  = mck_rdy_reg;
    ev            = '0;
    unique case (state_reg)
      // Keyed write beats the instruction when both arrive together
      LPM_ACTIVE: begin
        if (wr_hit(`LPM_ADDR_SUPPLY_CTRL) && wdata[`LPM_SC_REG_OFF_BIT] && key_ok) begin
          state_next = LPM_BACKUP;
          ev[`LPM_EV_BACKUP_ENTER] = 1'b1;
        end else if (wait_for_event_instruction && deep_sleep_reg) begin
          state_next = LPM_BACKUP;
          ev[`LPM_EV_BACKUP_ENTER] = 1'b1;
        end else if ((wr_hit(`LPM_ADDR_MAIN_OSC) && wdata[`LPM_MO_WAIT_REQ_BIT] && osc_key_ok
                      && flash_lp_reg <= 2'h1) || wait_for_event_instruction) begin
          state_next   = LPM_WAIT;
          mck_rdy_next = 1'b0;
          ev[`LPM_EV_WAIT_ENTER] = 1'b1;
        end
      end
      LPM_BACKUP: begin
        if (backup_wake) begin
          state_next    = LPM_RESTART;
          wake_cnt_next = 8'(`LPM_RESTART_CYCLES);
          ev[`LPM_EV_BACKUP_EXIT] = 1'b1;
        end
      end
      LPM_WAIT: begin
        if (wait_wake) begin
          state_next    = LPM_RESTART;
          wake_cnt_next = 8'(`LPM_RESTART_CYCLES);
          ev[`LPM_EV_WAIT_EXIT] = 1'b1;
        end
      end
      // Countdown stands for regulator and oscillator settling
      LPM_RESTART: begin
        if (wake_cnt_reg == 8'h00) begin
          state_next   = LPM_ACTIVE;
          mck_rdy_next = 1'b1;
        end else begin
          wake_cnt_next = wake_cnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = LPM_ACTIVE;
      end
    endcase
    if (wr_hit(`LPM_ADDR_SUPPLY_CTRL) && wdata[`LPM_SC_REG_OFF_BIT] && !key_ok)
      ev[`LPM_EV_KEY_ERROR] = 1'b1;
  end

  // Configuration registers and interrupt status
  always_comb begin
    xtal_next        = xtal_reg;
    deep_sleep_next  = deep_sleep_reg;
    fast_pins_next   = fast_pins_reg;
    fs_rtt_next      = fs_rtt_reg;
    fs_rtc_next      = fs_rtc_reg;
    fs_usb_next      = fs_usb_reg;
    flash_lp_next    = flash_lp_reg;
    wake_pin_en_next = wake_pin_en_reg;
    we_sm_next       = we_sm_reg;
    we_rtt_next      = we_rtt_reg;
    we_rtc_next      = we_rtc_reg;
    deb_lim_next     = deb_lim_reg;
    imask_next       = imask_reg;
    ist_next         = ist_reg;
    if (wr_hit(`LPM_ADDR_SUPPLY_CTRL) && key_ok)
      xtal_next = wdata[`LPM_SC_XTAL_SEL_BIT];
    if (wr_hit(`LPM_ADDR_SYS_CTRL))
      deep_sleep_next = wdata[`LPM_SYS_DEEP_SLEEP_BIT];
    if (wr_hit(`LPM_ADDR_FAST_STARTUP)) begin
      fast_pins_next = wdata[`LPM_FS_FAST_LSB +: 16];
      fs_rtt_next    = wdata[`LPM_FS_RTT_BIT];
      fs_rtc_next    = wdata[`LPM_FS_RTC_BIT];
      fs_usb_next    = wdata[`LPM_FS_USB_BIT];
      flash_lp_next  = wdata[`LPM_FS_FLASH_LP_LSB +: 2];
    end
    if (wr_hit(`LPM_ADDR_WAKE_ENABLE)) begin
      wake_pin_en_next = wdata[15:0];
      we_sm_next       = wdata[`LPM_WE_SM_BIT];
      we_rtt_next      = wdata[`LPM_WE_RTT_BIT];
      we_rtc_next      = wdata[`LPM_WE_RTC_BIT];
    end
    if (wr_hit(`LPM_ADDR_WAKE_CONFIG))
      deb_lim_next = wdata[DEB_W-1:0];
    if (wr_hit(`LPM_ADDR_IRQ_MASK))
      imask_next = wdata[4:0];
    // Set wins over a same-cycle clear
    if (wr_hit(`LPM_ADDR_IRQ_STATUS))
      ist_next = ist_reg & ~wdata[4:0];
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_next);
  end

  // Read mux, data valid in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (rd) begin
      unique case (addr)
        `LPM_ADDR_SUPPLY_CTRL:  rdata_next[`LPM_SC_XTAL_SEL_BIT] = xtal_reg;
        `LPM_ADDR_MAIN_OSC:     rdata_next = '0;
        `LPM_ADDR_FAST_STARTUP: rdata_next = {9'h000, flash_lp_reg, 2'b00, fs_usb_reg, fs_rtc_reg,
                                              fs_rtt_reg, fast_pins_reg};
        `LPM_ADDR_SYS_CTRL:     rdata_next[`LPM_SYS_DEEP_SLEEP_BIT] = deep_sleep_reg;
        `LPM_ADDR_PM_STATUS:    rdata_next = {24'h000000, 4'(state_reg), 3'b000, mck_rdy_reg};
        `LPM_ADDR_IRQ_STATUS:   rdata_next = {27'h0000000, ist_reg};
        `LPM_ADDR_IRQ_MASK:     rdata_next = {27'h0000000, imask_reg};
        `LPM_ADDR_WAKE_ENABLE:  rdata_next = {13'h0000, we_rtc_reg, we_rtt_reg, we_sm_reg, wake_pin_en_reg};
        `LPM_ADDR_WAKE_CONFIG:  rdata_next = {{(32-DEB_W){1'b0}}, deb_lim_reg};
        default:                rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg       <= LPM_ACTIVE;
      xtal_reg        <= 1'b0;
      deep_sleep_reg  <= 1'b0;
      fast_pins_reg   <= '0;
      fs_rtt_reg      <= 1'b0;
      fs_rtc_reg      <= 1'b0;
      fs_usb_reg      <= 1'b0;
      flash_lp_reg    <= '0;
      wake_pin_en_reg <= '0;
      we_sm_reg       <= 1'b0;
      we_rtt_reg      <= 1'b0;
      we_rtc_reg      <= 1'b0;
      deb_lim_reg     <= DEB_W'(`LPM_DEBOUNCE_DEFAULT);
      mck_rdy_reg     <= 1'b1;
      wake_cnt_reg    <= '0;
      ist_reg         <= '0;
      imask_reg       <= '0;
      rdata_reg       <= '0;
      irq_reg         <= 1'b0;
    end else if (ce) begin
      state_reg       <= state_next;
      xtal_reg        <= xtal_next;
      deep_sleep_reg  <= deep_sleep_next;
      fast_pins_reg   <= fast_pins_next;
      fs_rtt_reg      <= fs_rtt_next;
      fs_rtc_reg      <= fs_rtc_next;
      fs_usb_reg      <= fs_usb_next;
      flash_lp_reg    <= flash_lp_next;
      wake_pin_en_reg <= wake_pin_en_next;
      we_sm_reg       <= we_sm_next;
      we_rtt_reg      <= we_rtt_next;
      we_rtc_reg      <= we_rtc_next;
      deb_lim_reg     <= deb_lim_next;
      mck_rdy_reg     <= mck_rdy_next;
      wake_cnt_reg    <= wake_cnt_next;
      ist_reg         <= ist_next;
      imask_reg       <= imask_next;
      rdata_reg       <= rdata_next;
      irq_reg         <= irq_next;
    end
  end

  // Enables follow the next state, so they switch on the same edge as it
  always_comb begin
    regulator_on_next     = (state_next != LPM_BACKUP);
    core_supply_on_next   = (state_next != LPM_BACKUP);
    slow_osc_on_next      = 1'b1;
    supply_domain_on_next = 1'b1;
    // Clocks stay off through the restart countdown
    core_clk_en_next      = (state_next == LPM_ACTIVE);
    periph_clk_en_next    = (state_next == LPM_ACTIVE);
    mem_clk_en_next       = (state_next == LPM_ACTIVE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regulator_on_reg     <= 1'b1;
      core_supply_on_reg   <= 1'b1;
      slow_osc_on_reg      <= 1'b1;
      supply_domain_on_reg <= 1'b1;
      core_clk_en_reg      <= 1'b1;
      periph_clk_en_reg    <= 1'b1;
      mem_clk_en_reg       <= 1'b1;
    end else if (ce) begin
      regulator_on_reg     <= regulator_on_next;
      core_supply_on_reg   <= core_supply_on_next;
      slow_osc_on_reg      <= slow_osc_on_next;
      supply_domain_on_reg <= supply_domain_on_next;
      core_clk_en_reg      <= core_clk_en_next;
      periph_clk_en_reg    <= periph_clk_en_next;
      mem_clk_en_reg       <= mem_clk_en_next;
    end
  end

  // Every output is a flop, no decode after the register
  assign regulator_on      = regulator_on_reg;
  assign core_supply_on    = core_supply_on_reg;
  assign supply_domain_on  = supply_domain_on_reg;
  assign slow_osc_on       = slow_osc_on_reg;
  assign slow_osc_xtal_sel = xtal_reg;
  assign core_clk_en       = core_clk_en_reg;
  assign periph_clk_en     = periph_clk_en_reg;
  assign mem_clk_en        = mem_clk_en_reg;
  assign rdata             = rdata_reg;
  assign irq               = irq_reg;
endmodule : lpm_ctrl
`default_nettype wire

// ---- lpm_ctrl_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        wait_for_event_instruction,
  input wire logic        regulator_on,
  input wire logic        core_supply_on,
  input wire logic        slow_osc_on,
  input wire logic        slow_osc_xtal_sel,
  input wire logic        core_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        mem_clk_en,
  input wire logic        supply_domain_on,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic sc_wr;
  logic sc_key;
  logic act;
  assign sc_wr  = ce && wr && addr == 8'h00;
  assign sc_key = sc_wr && wdata[31:24] == 8'hA5;
  assign act    = core_clk_en && regulator_on;
  property p_backup_off;
    !regulator_on |-> !core_supply_on && !core_clk_en && slow_osc_on && supply_domain_on;
  endproperty
  a_backup_off: assert property (p_backup_off)
    else $error("backup supplies wrong");
  property p_wait_clk;
    !core_clk_en |-> !periph_clk_en && !mem_clk_en && slow_osc_on;
  endproperty
  a_wait_clk: assert property (p_wait_clk)
    else $error("clock enables disagree");
  property p_run_clk;
    core_clk_en |-> periph_clk_en && mem_clk_en && regulator_on && core_supply_on;
  endproperty
  a_run_clk: assert property (p_run_clk)
    else $error("running without supply");
  property p_reg_off;
    sc_key && wdata[2] && act |=> !regulator_on;
  endproperty
  a_reg_off: assert property (p_reg_off)
    else $error("keyed regulator off ignored");
  property p_bad_key;
    sc_wr && wdata[31:24] != 8'hA5 && act && !wait_for_event_instruction |=> regulator_on;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("bad key changed state");
  property p_wfe;
    wait_for_event_instruction && ce && act && !wr |=> !core_clk_en;
  endproperty
  a_wfe: assert property (p_wfe)
    else $error("wait for event not taken");
  property p_ready;
    ce && rd && addr == 8'h10 && act |=> rdata == 32'h0000_0011;
  endproperty
  a_ready: assert property (p_ready)
    else $error("status wrong while running");
  property p_rd_idle;
    ce && !rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");
  property p_xtal_hold;
    !sc_key |=> $stable(slow_osc_xtal_sel);
  endproperty
  a_xtal_hold: assert property (p_xtal_hold)
    else $error("slow source changed unasked");
  property p_xtal_set;
    sc_key |=> slow_osc_xtal_sel == $past(wdata[3]);
  endproperty
  a_xtal_set: assert property (p_xtal_set)
    else $error("slow source not taken");
  c_backup: cover property ($fell(regulator_on));
  c_wait: cover property (regulator_on && $fell(core_clk_en));
  c_irq: cover property ($rose(irq));
endmodule : lpm_ctrl_checker
bind lpm_ctrl lpm_ctrl_checker i_chk (.mclk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .wait_for_event_instruction, .regulator_on, .core_supply_on, .slow_osc_on, .slow_osc_xtal_sel,
  .core_clk_en, .periph_clk_en, .mem_clk_en, .supply_domain_on, .irq);
`default_nettype wire

// ---- test_low_power_mode_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_low_power_mode_control;
  import lpm_pkg::*;
  logic       mclk = 0, rst = 1, ce = 1, wr = 0, rd = 0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  lpm_pins_t  pins = 16'h0000;
  logic [4:0] ev   = 5'h00;
  logic       reg_on, sup_on, osc_on, xsel, cclk, pclk, mclk_en, dom_on, irq;
  int         n_fail = 0, n_tests = 0, n;
  always #50 mclk = ~mclk;
  lpm_ctrl i_dut (.mclk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .wake_pins(pins),
    .supply_monitor_alarm(ev[0]), .real_time_timer_alarm(ev[1]), .calendar_alarm(ev[2]),
    .usb_wake(ev[3]), .wait_for_event_instruction(ev[4]), .regulator_on(reg_on),
    .core_supply_on(sup_on), .slow_osc_on(osc_on), .slow_osc_xtal_sel(xsel), .core_clk_en(cclk),
    .periph_clk_en(pclk), .mem_clk_en(mclk_en), .supply_domain_on(dom_on), .irq(irq));
  task close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task chk_w(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t word %h exp %h", $time, g, e);
    end
  endtask : chk_w
  task chk_b(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t flag %b exp %b", $time, g, e);
    end
  endtask : chk_b
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1;
    @(posedge mclk);
    wr <= 0;
    #1;
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1;
    @(posedge mclk);
    rd <= 0;
    #1;
    chk_w(rdata, e);
  endtask : rd_chk
  // Index 4 is the wait-for-event pulse
  task pulse(input int k);
    @(posedge mclk);
    ev <= 5'(1 << k);
    @(posedge mclk);
    ev <= 5'h00;
    #1;
  endtask : pulse
  task wake_wait(input int lim);
    n = 0;
    while (cclk !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (cclk !== 1'b1) begin
      n_fail++;
      $display("mismatch %0t wake timeout", $time);
      close_out();
    end
  endtask : wake_wait
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    rd_chk(8'h10, 32'h0000_0011);
    wr_reg(8'h00, 32'h5A00_0004);
    chk_b(reg_on, 1'b1);
    rd_chk(8'h14, 32'h0000_0010);
    wr_reg(8'h18, 32'h0000_0010);
    chk_b(irq, 1'b1);
    wr_reg(8'h14, 32'h0000_0010);
    chk_b(irq, 1'b0);
    wr_reg(8'h1C, 32'h0007_0001);
    // Alternate keyed write and deep-sleep entry; pin wake last
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 1) begin
        wr_reg(8'h0C, 32'h0000_0004);
        pulse(4);
      end else
        wr_reg(8'h00, 32'hA500_000C);
      chk_b(reg_on, 1'b0);
      chk_b(sup_on, 1'b0);
      chk_b(osc_on & dom_on, 1'b1);
      chk_b(xsel, 1'b1);
      if (k < 3)
        pulse(k);
      else begin
        @(posedge mclk);
        pins <= 16'h0001;
      end
      wake_wait(40);
      chk_b(reg_on, 1'b1);
      rd_chk(8'h10, 32'h0000_0011);
      wr_reg(8'h0C, 32'h0000_0000);
    end
    rd_chk(8'h14, 32'h0000_0003);
    wr_reg(8'h08, 32'h0007_0001);
    // Pin falls back low as the fast wake for the first pass
    for (int k = 0; k < 4; k++) begin
      if (k == 2)
        pulse(4);
      else
        wr_reg(8'h04, 32'h0037_0004);
      chk_b(cclk | pclk | mclk_en, 1'b0);
      chk_b(reg_on & sup_on, 1'b1);
      rd_chk(8'h10, 32'h0000_0040);
      if (k == 0) begin
        @(posedge mclk);
        pins <= 16'h0000;
      end else
        pulse(k);
      wake_wait(100);
      chk_b(n < 100, 1'b1);
      rd_chk(8'h10, 32'h0000_0011);
    end
    rd_chk(8'h14, 32'h0000_000F);
    wr_reg(8'h08, 32'h0047_0001);
    wr_reg(8'h04, 32'h0037_0004);
    chk_b(cclk, 1'b1);
    close_out();
  end
endmodule : test_low_power_mode_control
`default_nettype wire
